// ### rtl/timer16_defines.vh
// Offsets, field positions, fixed top values and reset values of the 16-bit timer.
`ifndef TIMER16_DEFINES_VH
`define TIMER16_DEFINES_VH
`define ADDR_COUNT_LOW      8'h00
`define ADDR_COUNT_HIGH     8'h04
`define ADDR_CAPTURE_LOW    8'h08
`define ADDR_CAPTURE_HIGH   8'h0c
`define ADDR_COMPARE_A_LOW  8'h10
`define ADDR_COMPARE_A_HIGH 8'h14
`define ADDR_COMPARE_B_LOW  8'h18
`define ADDR_COMPARE_B_HIGH 8'h1c
`define ADDR_CONTROL_A      8'h20
`define ADDR_CONTROL_B      8'h24
`define ADDR_FLAGS          8'h28
`define ADDR_IRQ_ENABLE     8'h2c
`define CTLB_CS_LSB         0
`define CTLB_WGM_LSB        3
`define CTLB_EDGE_BIT       6
`define CTLB_ACSEL_BIT      7
`define FLAG_OVF_BIT        0
`define FLAG_CAP_BIT        5
`define TOP_FIX8            16'h00ff
`define TOP_FIX9            16'h01ff
`define TOP_FIX10           16'h03ff
`define CONTROL_RESET       8'h00
`define COUNT_RESET         16'h0000
`endif

// ### rtl/sync2.v
// Two flip-flop synchroniser for one level.
`default_nettype none
module sync2 (
    // Clock and reset.
    input  wire hclk,
    input  wire hresetn,
    // Level in and out.
    input  wire d,
    output reg  q
);
    reg meta;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta <= 1'b0;
            q    <= 1'b0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

// ### rtl/tick_gen.v
// Timer tick source: prescaled system clock or synchronised external edge.
`default_nettype none
module tick_gen (
    // Clock and reset.
    input  wire       hclk,
    input  wire       hresetn,
    // Selection and external clock.
    input  wire [2:0] clock_select_field,
    input  wire       ext_clk_sync,
    // Tick out.
    output wire       timer_tick
);
    reg  [9:0] pre;
    reg        ext_d;
    reg        sel;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre   <= 10'h000;
            ext_d <= 1'b0;
        end else begin
            pre   <= pre + 10'h001;
            ext_d <= ext_clk_sync;
        end
    end
    always @* begin
        case (clock_select_field)
            3'h1:    sel = 1'b1;
            3'h2:    sel = (pre[2:0] == 3'h7);
            3'h3:    sel = (pre[5:0] == 6'h3f);
            3'h4:    sel = (pre[7:0] == 8'hff);
            3'h5:    sel = (pre == 10'h3ff);
            3'h6:    sel = ext_d & ~ext_clk_sync;
            3'h7:    sel = ~ext_d & ext_clk_sync;
            default: sel = 1'b0;
        endcase
    end
    assign timer_tick = sel;
endmodule
`default_nettype wire

// ### rtl/timer16_counter_capture_access.v
// 16-bit timer/counter with input capture, byte access over AHB-Lite.
//
// The address map and the AHB-Lite slave port were chosen for this implementation.
`include "timer16_defines.vh"
`default_nettype none
module timer16_counter_capture_access (
    // Clock and reset.
    input  wire        hclk,
    input  wire        hresetn,
    // AHB-Lite slave.
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    // Pins.
    input  wire        capture_pin,
    input  wire        comparator_output,
    input  wire        ext_clock_pin,
    input  wire        overflow_irq_ack,
    input  wire        capture_irq_ack,
    // Status outputs.
    output wire        top_event,
    output wire        bottom_event,
    output wire        overflow_irq,
    output wire        capture_irq
);
    // ****************************************
    // Bus address phase capture
    // ****************************************
    reg        wr_pend;
    reg [7:0]  wr_addr;
    wire       rd_now;
    assign rd_now    = hsel & hready & htrans[1] & ~hwrite;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else if (hready) begin
            wr_pend <= hsel & htrans[1] & hwrite;
            wr_addr <= haddr;
        end
    end
    wire [7:0] wdata;
    assign wdata = hwdata[7:0];
    wire w_cnt_lo = wr_pend & (wr_addr == `ADDR_COUNT_LOW);
    wire w_cnt_hi = wr_pend & (wr_addr == `ADDR_COUNT_HIGH);
    wire w_cap_lo = wr_pend & (wr_addr == `ADDR_CAPTURE_LOW);
    wire w_cap_hi = wr_pend & (wr_addr == `ADDR_CAPTURE_HIGH);
    wire w_ca_lo  = wr_pend & (wr_addr == `ADDR_COMPARE_A_LOW);
    wire w_ca_hi  = wr_pend & (wr_addr == `ADDR_COMPARE_A_HIGH);
    wire w_cb_lo  = wr_pend & (wr_addr == `ADDR_COMPARE_B_LOW);
    wire w_cb_hi  = wr_pend & (wr_addr == `ADDR_COMPARE_B_HIGH);
    wire w_ctla   = wr_pend & (wr_addr == `ADDR_CONTROL_A);
    wire w_ctlb   = wr_pend & (wr_addr == `ADDR_CONTROL_B);
    wire w_flags  = wr_pend & (wr_addr == `ADDR_FLAGS);
    wire w_irqen  = wr_pend & (wr_addr == `ADDR_IRQ_ENABLE);
    wire r_cnt_lo = rd_now & (haddr == `ADDR_COUNT_LOW);
    wire r_cap_lo = rd_now & (haddr == `ADDR_CAPTURE_LOW);
    // ****************************************
    // Control registers
    // ****************************************
    reg  [7:0]  timer_control_a;
    reg  [7:0]  timer_control_b;
    reg  [7:0]  irq_enable;
    reg  [15:0] compare_a;
    reg  [15:0] compare_b;
    reg  [15:0] capture_value_r;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_control_a <= `CONTROL_RESET;
            timer_control_b <= `CONTROL_RESET;
            irq_enable      <= `CONTROL_RESET;
        end else begin
            if (w_ctla)
                timer_control_a <= wdata;
            if (w_ctlb)
                timer_control_b <= wdata;
            if (w_irqen)
                irq_enable <= wdata;
        end
    end
    wire [2:0] clock_select_field;
    wire [3:0] waveform_mode_field;
    wire       capture_edge_rise;
    wire       capture_from_comp;
    wire       capture_irq_enable;
    wire       overflow_irq_enable;
    assign clock_select_field  = timer_control_b[`CTLB_CS_LSB+2:`CTLB_CS_LSB];
    assign waveform_mode_field = {timer_control_b[`CTLB_WGM_LSB+1:`CTLB_WGM_LSB],
                                  timer_control_a[1:0]};
    assign capture_edge_rise   = timer_control_b[`CTLB_EDGE_BIT];
    assign capture_from_comp   = timer_control_b[`CTLB_ACSEL_BIT];
    assign capture_irq_enable  = irq_enable[`FLAG_CAP_BIT];
    assign overflow_irq_enable = irq_enable[`FLAG_OVF_BIT];
    // ****************************************
    // Mode decode
    // ****************************************
    reg [15:0] top_value;
    reg        updown;
    reg        top_is_cap;
    reg        ctc_mode;
    always @*
    begin
        top_value  = 16'hffff;
        updown     = 1'b0;
        top_is_cap = 1'b0;
        ctc_mode   = 1'b0;
        case (waveform_mode_field)
            4'h1: begin top_value = `TOP_FIX8;  updown = 1'b1; end
            4'h2: begin top_value = `TOP_FIX9;  updown = 1'b1; end
            4'h3: begin top_value = `TOP_FIX10; updown = 1'b1; end
            4'h4: begin top_value = compare_a;  ctc_mode = 1'b1; end
            4'h5: top_value = `TOP_FIX8;
            4'h6: top_value = `TOP_FIX9;
            4'h7: top_value = `TOP_FIX10;
            4'h8: begin top_value = capture_value_r; updown = 1'b1;
                        top_is_cap = 1'b1; end
            4'h9: begin top_value = compare_a; updown = 1'b1; end
            4'ha: begin top_value = capture_value_r; updown = 1'b1;
                        top_is_cap = 1'b1; end
            4'hb: begin top_value = compare_a; updown = 1'b1; end
            4'hc: begin top_value = capture_value_r; ctc_mode = 1'b1;
                        top_is_cap = 1'b1; end
            4'he: begin top_value = capture_value_r; top_is_cap = 1'b1; end
            4'hf: top_value = compare_a;
            default: top_value = 16'hffff;
        endcase
    end
    // ****************************************
    // Counter, holding register, capture
    // ****************************************
    reg  [15:0] count_value;
    reg  [7:0]  holding;
    reg         count_down;
    reg         overflow_flag;
    reg         capture_flag;
    wire        timer_tick;
    wire        ext_sync;
    wire        cap_pin_sync;
    wire        comp_sync;
    reg         trig_d;
    sync2 u_sync_ext (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       (ext_clock_pin),
        .q       (ext_sync)
    );
    sync2 u_sync_cap (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       (capture_pin),
        .q       (cap_pin_sync)
    );
    sync2 u_sync_comp (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       (comparator_output),
        .q       (comp_sync)
    );
    tick_gen u_tick (
        .hclk               (hclk),
        .hresetn            (hresetn),
        .clock_select_field (clock_select_field),
        .ext_clk_sync       (ext_sync),
        .timer_tick         (timer_tick)
    );
    assign top_event    = (count_value == top_value);
    assign bottom_event = (count_value == 16'h0000);
    wire trig;
    assign trig = capture_from_comp ? comp_sync : cap_pin_sync;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            trig_d <= 1'b0;
        else
            trig_d <= trig;
    end
    wire cap_event;
    assign cap_event = ~top_is_cap &
                       (capture_edge_rise ? (trig & ~trig_d)
                                          : (~trig & trig_d));
    reg        ovf_set;
    reg [15:0] next_count;
    reg        next_down;
    always @*
    begin
        next_count = count_value;
        next_down  = count_down;
        ovf_set    = 1'b0;
        if (timer_tick) begin
            if (updown) begin
                if (count_down) begin
                    next_count = count_value - 16'h0001;
                    if (count_value == 16'h0001) begin
                        next_down = 1'b0;
                        ovf_set   = 1'b1;
                    end
                    if (bottom_event) begin
                        next_count = 16'h0001;
                        next_down  = 1'b0;
                        ovf_set    = 1'b1;
                    end
                end else if (top_event) begin
                    next_count = count_value - 16'h0001;
                    next_down  = 1'b1;
                end else begin
                    next_count = count_value + 16'h0001;
                end
            end else if (top_event) begin
                next_count = 16'h0000;
                ovf_set    = ~ctc_mode | (waveform_mode_field == 4'h0);
            end else begin
                next_count = count_value + 16'h0001;
            end
            if (ctc_mode && top_event)
                ovf_set = 1'b0;
            if (count_value == 16'hffff)
                ovf_set = 1'b1;
        end
        if (w_cnt_lo) begin
            next_count = {holding, wdata};
        end
    end
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_value     <= `COUNT_RESET;
            count_down      <= 1'b0;
            capture_value_r <= `COUNT_RESET;
            holding         <= 8'h00;
            compare_a       <= 16'hffff;
            compare_b       <= 16'hffff;
            overflow_flag   <= 1'b0;
            capture_flag    <= 1'b0;
        end else begin
            count_value <= next_count;
            count_down  <= next_down;
            if (r_cnt_lo)
                holding <= count_value[15:8];
            else if (r_cap_lo)
                holding <= capture_value_r[15:8];
            else if (w_cnt_hi | w_cap_hi | w_ca_hi | w_cb_hi)
                holding <= wdata;
            if (w_ca_lo)
                compare_a <= {holding, wdata};
            if (w_cb_lo)
                compare_b <= {holding, wdata};
            if (w_cap_lo && top_is_cap)
                capture_value_r <= {holding, wdata};
            else if (cap_event)
                capture_value_r <= count_value;
            if (cap_event)
                capture_flag <= 1'b1;
            else if ((w_flags && wdata[`FLAG_CAP_BIT]) || capture_irq_ack)
                capture_flag <= 1'b0;
            if (ovf_set)
                overflow_flag <= 1'b1;
            else if ((w_flags && wdata[`FLAG_OVF_BIT]) || overflow_irq_ack)
                overflow_flag <= 1'b0;
        end
    end
    assign capture_irq  = capture_flag & capture_irq_enable;
    assign overflow_irq = overflow_flag & overflow_irq_enable;
    // ****************************************
    // Read data
    // ****************************************
    reg [7:0] rd_byte;
    always @*
    begin
        case (haddr)
            `ADDR_COUNT_LOW:      rd_byte = count_value[7:0];
            `ADDR_COUNT_HIGH:     rd_byte = holding;
            `ADDR_CAPTURE_LOW:    rd_byte = capture_value_r[7:0];
            `ADDR_CAPTURE_HIGH:   rd_byte = holding;
            `ADDR_COMPARE_A_LOW:  rd_byte = compare_a[7:0];
            `ADDR_COMPARE_A_HIGH: rd_byte = compare_a[15:8];
            `ADDR_COMPARE_B_LOW:  rd_byte = compare_b[7:0];
            `ADDR_COMPARE_B_HIGH: rd_byte = compare_b[15:8];
            `ADDR_CONTROL_A:      rd_byte = timer_control_a;
            `ADDR_CONTROL_B:      rd_byte = timer_control_b;
            `ADDR_FLAGS:          rd_byte = {2'h0, capture_flag, 4'h0,
                                             overflow_flag};
            `ADDR_IRQ_ENABLE:     rd_byte = irq_enable;
            default:              rd_byte = 8'h00;
        endcase
    end
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (rd_now)
            hrdata <= {24'h000000, rd_byte};
    end
    wire unused_ok;
    assign unused_ok = &{hsize, htrans[0], hwdata[31:8], 1'b0};
endmodule
`default_nettype wire

// ### tb/timer16_counter_capture_access_sva.sv
// Port assertions for the 16-bit timer with capture and byte access.
`include "timer16_defines.vh"
`default_nettype none
module timer16_sva (
    // Clock and reset.
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus.
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Pins and status.
    input wire logic        capture_pin,
    input wire logic        comparator_output,
    input wire logic        capture_irq_ack,
    input wire logic        bottom_event,
    input wire logic        overflow_irq,
    input wire logic        capture_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // Helper state: pending write and a copy of the holding byte.
    // ************************************************************
    logic       rd;
    logic       wr;
    logic       hi_w;
    logic       lo_r;
    logic       wr_pend;
    logic       hold_ok;
    logic [7:0] wr_addr;
    logic [7:0] hold;
    logic [2:0] quiet;
    assign rd = hsel && hready && htrans[1] && !hwrite;
    assign wr = hsel && hready && htrans[1] && hwrite;
    assign hi_w = wr_pend && wr_addr[2] && wr_addr < `ADDR_CONTROL_A;
    assign lo_r = rd && (haddr == `ADDR_COUNT_LOW
                      || haddr == `ADDR_CAPTURE_LOW);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hold <= 8'h00;
            hold_ok <= 1'b1;
            quiet <= 3'h0;
        end else begin
            wr_pend <= wr;
            wr_addr <= wr ? haddr : wr_addr;
            hold <= hi_w ? hwdata[7:0] : hold;
            hold_ok <= !lo_r && (hi_w || hold_ok);
            if ($changed(capture_pin) || $changed(comparator_output)) begin
                quiet <= 3'h0;
            end else if (quiet != 3'h7) begin
                quiet <= quiet + 3'h1;
            end
        end
    end
    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_ready_always: assert property (hreadyout)
        else $error("slave not ready");
    a_okay_resp: assert property (!hresp)
        else $error("error response");
    a_upper_zero: assert property (hrdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_rdata_holds: assert property (!rd |=> $stable(hrdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (
        rd && haddr >= 8'h30 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_hold_return: assert property (rd && !hi_w && hold_ok &&
        (haddr == `ADDR_COUNT_HIGH || haddr == `ADDR_CAPTURE_HIGH)
        |=> hrdata == {24'h0, hold})
        else $error("high read not from holding byte");
    a_ack_clears: assert property (
        capture_irq_ack && quiet == 3'h7 |=> !capture_irq)
        else $error("capture request not cleared by ack");
    a_reset_state: assert property ($rose(hresetn) |->
        bottom_event && !overflow_irq && !capture_irq && hrdata == 32'h0)
        else $error("wrong state after reset");
endmodule
bind timer16_counter_capture_access timer16_sva u_sva (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .capture_pin, .comparator_output,
    .capture_irq_ack, .bottom_event, .overflow_irq, .capture_irq
);
`default_nettype wire

// ### tb/cpu_bus_model.sv
// Processor model issuing byte transfers over AHB-Lite.
`default_nettype none
module cpu_bus_model (
    // Clock.
    input  wire logic        hclk,
    // AHB-Lite master.
    output var  logic        hsel,
    output var  logic [7:0]  haddr,
    output var  logic [1:0]  htrans,
    output var  logic        hwrite,
    output var  logic [2:0]  hsize,
    output var  logic [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h5a5a5a5a;
    end
    // One single transfer: address phase, then data phase.
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= w ? {24'h0, d} : ~hwdata;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata[7:0];
        hsel <= 1'b0;
        hwdata <= ~hwdata;
    endtask
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        logic [7:0] q;
        xfer(1'b1, a + 8'h04, v[15:8], q);
        xfer(1'b1, a, v[7:0], q);
    endtask
    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        xfer(1'b0, a, 8'h00, v[7:0]);
        xfer(1'b0, a + 8'h04, 8'h00, v[15:8]);
    endtask
endmodule
`default_nettype wire

// ### tb/timer16_counter_capture_access_test.sv
// Self-checking bench of the 16-bit timer byte access and capture.
`include "timer16_defines.vh"
`default_nettype none
module timer16_counter_capture_access_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata;
    logic        capture_pin, comparator_output, ext_clock_pin;
    logic        overflow_irq_ack, capture_irq_ack;
    logic        top_event, bottom_event, overflow_irq, capture_irq;
    logic [3:0]  flags;
    logic [31:0] seed = 32'hd1f5;
    int          fails = 0;
    int          comparisons = 0;
    logic [15:0] pats [4] = '{16'h01ff, 16'hffff, 16'h0000, 16'h8001};
    logic [3:0]  wgm [5] = '{4'd5, 4'd6, 4'd7, 4'd14, 4'd15};
    assign flags = {capture_irq, overflow_irq, bottom_event, top_event};
    function automatic logic [15:0] rnd16();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    function automatic logic [15:0] top_for(input logic [3:0] m,
                                             input logic [15:0] c, a);
        case (m)
            4'd5: return `TOP_FIX8;
            4'd6: return `TOP_FIX9;
            4'd7: return `TOP_FIX10;
            4'd14: return c;
            default: return a;
        endcase
    endfunction
    task automatic chk(input logic [15:0] got, exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic flag(input int s, input logic l, input int n,
                        input string what);
        @(negedge hclk);
        for (int k = 1; k < n && flags[s] !== l; k++) @(negedge hclk);
        chk({15'h0, flags[s]}, {15'h0, l}, what);
    endtask
    task automatic wb(input logic [7:0] a, d);
        logic [7:0] q;
        cpu.xfer(1'b1, a, d, q);
    endtask
    task automatic test_done();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    cpu_bus_model cpu (.hclk, .hsel, .haddr, .htrans, .hwrite, .hsize,
                       .hwdata, .hready(hreadyout), .hrdata);
    timer16_counter_capture_access dut (.hclk, .hresetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
        .hreadyout, .hresp, .capture_pin, .comparator_output,
        .ext_clock_pin, .overflow_irq_ack, .capture_irq_ack, .top_event,
        .bottom_event, .overflow_irq, .capture_irq);
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    initial begin
        repeat (20000) @(posedge hclk);
        fails++;
        test_done();
    end
    initial begin : main
        logic [15:0] v, w, c, got;
        hresetn = 1'b0;
        {capture_pin, comparator_output, ext_clock_pin} = 3'b000;
        {overflow_irq_ack, capture_irq_ack} = 2'b00;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        cpu.rd16(8'h30, got);
        cpu.rd16(`ADDR_COMPARE_A_LOW, got);
        chk(got, 16'hffff, "compare reset");
        for (int i = 0; i < 8; i++) begin
            v = (i < 4) ? pats[i] : rnd16();
            cpu.wr16(`ADDR_COUNT_LOW, v);
            repeat (8) @(posedge hclk);
            cpu.rd16(`ADDR_COUNT_LOW, got);
            chk(got, v, "count stopped");
        end
        $display("end: byte access");
        v = rnd16() | 16'h0002;
        w = rnd16();
        cpu.wr16(`ADDR_COMPARE_A_LOW, v);
        wb(`ADDR_COMPARE_B_LOW, w[7:0]);
        cpu.rd16(`ADDR_COMPARE_B_LOW, got);
        chk(got, {v[15:8], w[7:0]}, "shared high");
        wb(`ADDR_COUNT_HIGH, w[15:8]);
        cpu.xfer(1'b0, `ADDR_COMPARE_A_HIGH, 8'h00, got[7:0]);
        chk({8'h0, got[7:0]}, {8'h0, v[15:8]}, "compare high");
        cpu.xfer(1'b0, `ADDR_COUNT_HIGH, 8'h00, got[7:0]);
        chk({8'h0, got[7:0]}, {8'h0, w[15:8]}, "holding kept");
        $display("end: shared holding byte");
        c = rnd16() & 16'h7fff;
        cpu.wr16(`ADDR_COUNT_LOW, c);
        wb(`ADDR_CONTROL_B, 8'h07);
        for (int i = 0; i < 5; i++) begin
            ext_clock_pin <= 1'b1;
            repeat (4) @(posedge hclk);
            ext_clock_pin <= 1'b0;
            repeat (4) @(posedge hclk);
        end
        repeat (6) @(posedge hclk);
        wb(`ADDR_CONTROL_B, 8'h00);
        cpu.rd16(`ADDR_COUNT_LOW, got);
        chk(got, c + 16'd5, "external ticks");
        wb(`ADDR_IRQ_ENABLE, 8'h21);
        wb(`ADDR_CONTROL_B, 8'h01);
        repeat (20) @(posedge hclk);
        cpu.wr16(`ADDR_COUNT_LOW, 16'hfff0);
        flag(0, 1'b1, 40, "top");
        flag(1, 1'b1, 4, "bottom");
        flag(2, 1'b1, 4, "overflow");
        wb(`ADDR_CONTROL_B, 8'h00);
        overflow_irq_ack <= 1'b1;
        @(posedge hclk);
        overflow_irq_ack <= 1'b0;
        flag(2, 1'b0, 3, "overflow ack");
        wb(`ADDR_CONTROL_A, 8'h01);
        cpu.wr16(`ADDR_COUNT_LOW, 16'h00fd);
        wb(`ADDR_CONTROL_B, 8'h01);
        flag(0, 1'b1, 8, "dual-slope top");
        flag(2, 1'b0, 1, "no overflow at top");
        flag(1, 1'b1, 300, "dual-slope bottom");
        flag(2, 1'b1, 2, "dual-slope overflow");
        wb(`ADDR_CONTROL_B, 8'h00);
        wb(`ADDR_CONTROL_A, 8'h00);
        cpu.wr16(`ADDR_COUNT_LOW, c);
        wb(`ADDR_CONTROL_B, 8'h02);
        repeat (61) @(posedge hclk);
        wb(`ADDR_CONTROL_B, 8'h00);
        cpu.rd16(`ADDR_COUNT_LOW, got);
        chk(got, c + 16'h0008, "prescaled ticks");
        $display("end: counting");
        c = rnd16() | 16'h0400;
        cpu.wr16(`ADDR_CAPTURE_LOW, c);
        cpu.rd16(`ADDR_CAPTURE_LOW, got);
        chk(got, 16'h0000, "capture locked");
        for (int m = 0; m < 5; m++) begin
            wb(`ADDR_CONTROL_A, {6'h0, wgm[m][1:0]});
            wb(`ADDR_CONTROL_B, {3'h0, wgm[m][3:2], 3'h0});
            if (m == 3) cpu.wr16(`ADDR_CAPTURE_LOW, c);
            w = top_for(wgm[m], c, v);
            cpu.wr16(`ADDR_COUNT_LOW, w - 16'd1);
            flag(0, 1'b0, 1, "below top");
            cpu.wr16(`ADDR_COUNT_LOW, w);
            flag(0, 1'b1, 1, "at top");
        end
        $display("end: top values");
        wb(`ADDR_CONTROL_A, 8'h00);
        wb(`ADDR_CONTROL_B, 8'h40);
        v = rnd16();
        cpu.wr16(`ADDR_COUNT_LOW, v);
        capture_pin <= 1'b1;
        flag(3, 1'b1, 10, "capture");
        cpu.rd16(`ADDR_CAPTURE_LOW, got);
        chk(got, v, "captured count");
        capture_irq_ack <= 1'b1;
        @(posedge hclk);
        capture_irq_ack <= 1'b0;
        flag(3, 1'b0, 2, "capture ack");
        w = rnd16();
        cpu.wr16(`ADDR_COUNT_LOW, w);
        capture_pin <= 1'b0;
        repeat (10) @(posedge hclk);
        flag(3, 1'b0, 1, "wrong edge");
        wb(`ADDR_CONTROL_B, 8'hc0);
        comparator_output <= 1'b1;
        flag(3, 1'b1, 10, "comparator");
        cpu.rd16(`ADDR_CAPTURE_LOW, got);
        chk(got, w, "comparator capture");
        wb(`ADDR_FLAGS, 8'h20);
        flag(3, 1'b0, 2, "flag write");
        $display("end: capture");
        test_done();
    end
endmodule
`default_nettype wire
